// ---- rtl/capc_consts.svh ----
// constants of the command/address parity checker
//
// Behaviour
// - mode latency code: 000 off, 001/010/011 give 4/5/6 clocks; off at reset
// - while enabled, every selected command is held the latency before use
// - parity covers act, ras/cas/we, address, bank, group; unused pins zero
// - covered bits plus parity input must hold an even count of ones
// - a faulty command is dropped; a dropped read never drives strobes
// - first faulty command is logged and kept until status is cleared
// - status bit four is set before the minimum alert pulse ends
// - alert goes low within the onset delay of the faulty command
// - drain, wait row time, close banks, execute nothing in alert window
// - release alert only after minimum width and all banks idle
// - after the window commands run delayed; unchecked until status cleared
// - latency write-only, status read/write; writing one is ignored
// - latency is added to every command, so to read and write latency
// - persistent bit nine resumes checking after release despite status
// - several errors in persistent mode leave the log undefined
// - faulty self-refresh entry is dropped and power-down entered
// - log readable on readback page one with status and latency word
`ifndef CAPC_CONSTS_SVH
`define CAPC_CONSTS_SVH

// clock and times, ns figures as given, cycles derived
`define CAPC_CLK_MHZ      200
`define CAPC_ALERT_ON_NS  10
`define CAPC_ALERT_PW_NS  64
`define CAPC_TRAS_NS      33
`define CAPC_ALERT_ON_CYC ((`CAPC_ALERT_ON_NS*`CAPC_CLK_MHZ)/1000)
`define CAPC_ALERT_PW_CYC ((`CAPC_ALERT_PW_NS*`CAPC_CLK_MHZ+999)/1000)
`define CAPC_TRAS_CYC     ((`CAPC_TRAS_NS*`CAPC_CLK_MHZ+999)/1000)
`define CAPC_WINDOW_CYC   (`CAPC_ALERT_ON_CYC+`CAPC_ALERT_PW_CYC)

// register byte offsets
`define CAPC_OFS_MODE  8'h00
`define CAPC_OFS_PAGE  8'h04
`define CAPC_OFS_STAT  8'h08
`define CAPC_OFS_LOG0  8'h10
`define CAPC_OFS_LOG1  8'h14
`define CAPC_OFS_LOG2  8'h18
`define CAPC_OFS_LOG3  8'h1c

// mode register fields
`define CAPC_LAT_MSB   2
`define CAPC_STAT_BIT  4
`define CAPC_PERS_BIT  9
`define CAPC_LAT_OFF   3'h0
`define CAPC_LAT_PL4   3'h1
`define CAPC_LAT_PL5   3'h2
`define CAPC_LAT_PL6   3'h3
`define CAPC_PL4_CYC   3'h4
`define CAPC_PL5_CYC   3'h5
`define CAPC_PL6_CYC   3'h6

// command word and pin vector layout
`define CAPC_WORD_W    21
`define CAPC_PIN_W     24
`define CAPC_F_WE      14
`define CAPC_F_CAS     15
`define CAPC_F_RAS     16
`define CAPC_F_ACT     17
`define CAPC_F_BA0     18
`define CAPC_F_BA1     19
`define CAPC_F_BG0     20
`define CAPC_P_PAR     21
`define CAPC_P_CS      22
`define CAPC_P_CKE     23
`define CAPC_CNT_W     10

`endif

// ---- rtl/capc_pkg.sv ----
// types of the command/address parity checker
package capc_pkg;
`include "capc_consts.svh"

   typedef enum logic [1:0] {
      CAPC_RUN   = 2'b00,
      CAPC_DRAIN = 2'b01,
      CAPC_PRECH = 2'b11,
      CAPC_HOLD  = 2'b10
   } capc_state_t;

   typedef struct packed {
      logic [`CAPC_PIN_W-1:0]  pin1;
      logic [`CAPC_PIN_W-1:0]  pin2;
      logic                    wr_pend;
      logic [7:0]              wr_ofs;
      logic [2:0]              lat;
      logic                    status;
      logic                    persist;
      logic                    page_sel;
      logic [`CAPC_WORD_W:0]   log;
      capc_state_t             state;
      logic [`CAPC_CNT_W-1:0]  cnt;
      logic                    alert_n;
      logic                    exec_valid;
      logic [`CAPC_WORD_W-1:0] exec_word;
      logic                    prech_all;
      logic                    pd_enter;
      logic [2:0]              pl_cycles;
      logic [31:0]             hrdata;
   } capc_top_t;

endpackage : capc_pkg

// ---- rtl/capc_dly_if.sv ----
// carrier between the checker and its latency delay line
`timescale 1ns/10ps
interface capc_dly_if #(
   parameter int W  = 21,
   parameter int SW = 3
);
   logic          push_valid;
   logic [W-1:0]  push_word;
   logic          flush;
   logic [SW-1:0] sel;
   logic          tap_valid;
   logic [W-1:0]  tap_word;

   modport src (output push_valid, push_word, flush, sel,
                input tap_valid, tap_word);
   modport dly (input push_valid, push_word, flush, sel,
                output tap_valid, tap_word);
endinterface : capc_dly_if

// ---- rtl/capc_delay_line.sv ----
// shift line that holds accepted commands for the parity latency
`timescale 1ns/10ps
module capc_delay_line #(
   parameter int DEPTH = 6,
   parameter int W     = 21
)(
   input wire logic core_clk,
   input wire logic rst_n,
   capc_dly_if.dly  port
);
   typedef struct packed {
      logic [DEPTH-1:0]        vld;
      logic [DEPTH-1:0][W-1:0] word;
   } capc_dly_t;

   capc_dly_t cur;
   capc_dly_t nx;

   // shift one stage per clock; a flush kills every held command
   always_comb begin
      nx = cur;
      nx.vld[0] = port.push_valid;
      nx.word[0] = port.push_word;
      for (int i = 1; i < DEPTH; i++) begin
         nx.vld[i] = cur.vld[i-1];
         nx.word[i] = cur.word[i-1];
      end
      if (port.flush) begin
         nx.vld = '0; // uncertain-window commands are not run
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= nx;
      end
   end

   // tap chosen by the latency; out-of-range select reads stage zero
   assign port.tap_valid = (int'(port.sel) < DEPTH) ?
                           cur.vld[port.sel] : cur.vld[0];
   assign port.tap_word  = (int'(port.sel) < DEPTH) ?
                           cur.word[port.sel] : cur.word[0];

   chk_flush_empties: assert property (@(posedge core_clk)
      disable iff (!rst_n) port.flush |=> !port.tap_valid)
      else $error("delay line still valid after flush");

endmodule : capc_delay_line

// ---- rtl/capc_checker.sv ----
// command/address parity checker with latency, alert and error log
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "capc_consts.svh"
module capc_checker
   import capc_pkg::*;
#(
   parameter int DEPTH = 6
)(
   input  wire logic                    core_clk,
   input  wire logic                    nrst,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire logic                    cke,
   input  wire logic                    cs_n,
   input  wire logic                    act_n,
   input  wire logic                    ras_n,
   input  wire logic                    cas_n,
   input  wire logic                    we_n,
   input  wire logic [13:0]             addr,
   input  wire logic [1:0]              ba,
   input  wire logic                    bg,
   input  wire logic                    par,
   input  wire logic                    core_idle,
   input  wire logic                    banks_idle,
   output logic                         exec_valid,
   output logic      [`CAPC_WORD_W-1:0] exec_word,
   output logic                         prech_all,
   output logic                         pd_enter,
   output logic      [2:0]              pl_cycles,
   output logic                         alert_n
);
   localparam logic [`CAPC_CNT_W-1:0] TRAS_CNT = `CAPC_CNT_W'(`CAPC_TRAS_CYC);
   localparam logic [`CAPC_CNT_W-1:0] WIN_CNT =
      `CAPC_CNT_W'(`CAPC_WINDOW_CYC);
   localparam int ON_CYC = `CAPC_ALERT_ON_CYC;

   capc_top_t                cur;
   capc_top_t                nx;
   logic [1:0]               rst_ff;
   logic                     rst_n;
   logic [`CAPC_WORD_W-1:0]  cmd_word;
   logic                     cmd_par;
   logic                     cmd_sel;
   logic                     cmd_odd;
   logic                     pl_en;
   logic                     chk_on;
   logic                     err_now;
   logic                     run_ok;
   logic                     acc_now;
   logic                     is_sre;
   logic                     ahb_go;
   logic [`CAPC_CNT_W-1:0]   cnt_inc;

   capc_dly_if #(.W(`CAPC_WORD_W), .SW(3)) dly ();

   // latency code to added clocks; reserved codes act as disabled
   function automatic logic [2:0] pl_decode(input logic [2:0] code);
      case (code)
         `CAPC_LAT_PL4: pl_decode = `CAPC_PL4_CYC;
         `CAPC_LAT_PL5: pl_decode = `CAPC_PL5_CYC;
         `CAPC_LAT_PL6: pl_decode = `CAPC_PL6_CYC;
         default:       pl_decode = 3'h0;
      endcase
   endfunction : pl_decode

   // register read mux; log words read zero unless page one is selected
   function automatic logic [31:0] rd_mux(input logic [31:0] a,
                                          input capc_top_t s);
      logic [31:0] d;
      d = 32'h0;
      if (a[31:8] == 24'h0) begin
         case (a[7:0])
            `CAPC_OFS_MODE: begin
               // latency reads zero: write-only field
               d[`CAPC_STAT_BIT] = s.status;
               d[`CAPC_PERS_BIT] = s.persist;
            end
            `CAPC_OFS_PAGE: d[0] = s.page_sel;
            `CAPC_OFS_STAT: d[3:0] = {chk_on, s.state, !s.alert_n};
            `CAPC_OFS_LOG0: d[7:0] = s.page_sel ? s.log[7:0] : 8'h0;
            `CAPC_OFS_LOG1: d[7:0] = s.page_sel ?
               {s.log[`CAPC_F_CAS], s.log[`CAPC_F_WE], s.log[13:8]} : 8'h0;
            `CAPC_OFS_LOG2: d[7:0] = s.page_sel ?
               {s.log[`CAPC_P_PAR], s.log[`CAPC_F_ACT], 1'b0,
                s.log[`CAPC_F_BG0], s.log[`CAPC_F_BA1], s.log[`CAPC_F_BA0],
                1'b0, s.log[`CAPC_F_RAS]} : 8'h0; // absent pins as zero
            `CAPC_OFS_LOG3: d[7:0] = s.page_sel ?
               {1'b0, s.status, s.lat, 3'h0} : 8'h0;
            default: d = 32'h0;
         endcase
      end
      rd_mux = d;
   endfunction : rd_mux

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_ff <= 2'b00;
      end else begin
         rst_ff <= {rst_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_ff[1];

   ////////////////////////////////////////////////////////////////////////
   // command decode on the synchronised pins
   assign cmd_word = cur.pin2[`CAPC_WORD_W-1:0];
   assign cmd_par  = cur.pin2[`CAPC_P_PAR];
   assign cmd_sel  = !cur.pin2[`CAPC_P_CS];
   assign cmd_odd  = ^{cmd_par, cmd_word}; // even parity over all
   assign pl_en    = pl_decode(cur.lat) != 3'h0;
   // checking off while status set, unless persistent
   assign chk_on   = pl_en && (!cur.status || cur.persist) &&
                     (cur.state == CAPC_RUN);
   assign err_now  = chk_on && cmd_sel && cmd_odd;
   assign run_ok   = (cur.state == CAPC_RUN) && !err_now;
   assign acc_now  = cmd_sel && run_ok; // faulty command never accepted
   assign is_sre   = cmd_sel && !cur.pin2[`CAPC_P_CKE] &&
                     !cmd_word[`CAPC_F_RAS] && !cmd_word[`CAPC_F_CAS] &&
                     cmd_word[`CAPC_F_ACT] && cmd_word[`CAPC_F_WE];
   assign ahb_go   = hsel && htrans[1] && hready;
   assign cnt_inc  = (cur.cnt == '1) ? cur.cnt : cur.cnt + 1'b1;

   // delay line feed; stage k plus output flop adds k+1 clocks, so the
   // code 1..3 picks stage 3..5 for 4..6 clocks; needs six stages
   assign dly.push_valid = acc_now && pl_en;
   assign dly.push_word  = cmd_word;
   assign dly.flush      = err_now;
   assign dly.sel        = cur.lat + 3'h2;

   capc_delay_line #(.DEPTH(DEPTH), .W(`CAPC_WORD_W)) u_delay (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .port     (dly.dly)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state of the whole block
   always_comb begin
      nx = cur;
      // pins pass two flops before any decode
      nx.pin1 = {cke, cs_n, par, bg, ba, act_n, ras_n, cas_n, we_n, addr};
      nx.pin2 = cur.pin1;
      nx.prech_all = 1'b0;
      nx.pd_enter = 1'b0;
      nx.exec_valid = 1'b0;

      // data phase of a register write; whole words only
      if (cur.wr_pend) begin
         case (cur.wr_ofs)
            `CAPC_OFS_MODE: begin
               nx.lat = hwdata[`CAPC_LAT_MSB:0];
               nx.persist = hwdata[`CAPC_PERS_BIT];
               if (!hwdata[`CAPC_STAT_BIT]) begin
                  nx.status = 1'b0; // a one here is ignored
               end
            end
            `CAPC_OFS_PAGE: nx.page_sel = hwdata[0];
            default: nx.page_sel = cur.page_sel;
         endcase
      end

      // error: set wins over a clear in the same cycle
      if (err_now) begin
         nx.status = 1'b1;
         if (!cur.status) begin
            nx.log = {cmd_par, cmd_word}; // first error only
         end
         nx.pd_enter = is_sre; // dropped entry becomes power-down
      end

      // alert sequence: drain, precharge all, hold out the window
      case (cur.state)
         CAPC_RUN: begin
            if (err_now) begin
               nx.state = CAPC_DRAIN;
               nx.cnt = '0;
            end
         end
         CAPC_DRAIN: begin
            nx.cnt = cnt_inc;
            if (core_idle && cur.cnt >= TRAS_CNT) begin
               nx.state = CAPC_PRECH;
               nx.prech_all = 1'b1;
            end
         end
         CAPC_PRECH: begin
            nx.cnt = cnt_inc;
            if (banks_idle) begin
               nx.state = CAPC_HOLD;
            end
         end
         CAPC_HOLD: begin
            nx.cnt = cnt_inc;
            if (cur.cnt >= WIN_CNT && banks_idle) begin
               nx.state = CAPC_RUN;
            end
         end
         default: nx.state = CAPC_RUN;
      endcase
      nx.alert_n = (nx.state == CAPC_RUN); // low at the next edge

      // execution: direct when off, else from the delay line
      if (pl_en) begin
         nx.exec_valid = dly.tap_valid && run_ok;
         nx.exec_word = dly.tap_word;
      end else begin
         nx.exec_valid = acc_now;
         nx.exec_word = cmd_word;
      end
      nx.pl_cycles = pl_decode(nx.lat); // latency for read/write timing

      // bus: capture address phase; read data from post-write values
      nx.wr_pend = ahb_go && hwrite;
      nx.wr_ofs = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
      nx.hrdata = (ahb_go && !hwrite) ? rd_mux(haddr, nx) : 32'h0;
   end

   // all state but the reset flops and the delay line registered here; checking starts disabled
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
         cur.alert_n <= 1'b1;
         // sync flops start deselected, else reset looks like a command
         cur.pin1[`CAPC_P_CS] <= 1'b1;
         cur.pin2[`CAPC_P_CS] <= 1'b1;
      end else begin
         cur <= nx;
      end
   end

   assign hrdata     = cur.hrdata;
   assign hreadyout  = rst_ff[1];
   assign hresp      = 1'b0;
   assign exec_valid = cur.exec_valid;
   assign exec_word  = cur.exec_word;
   assign prech_all  = cur.prech_all;
   assign pd_enter   = cur.pd_enter;
   assign pl_cycles  = cur.pl_cycles;
   assign alert_n    = cur.alert_n;

   ////////////////////////////////////////////////////////////////////////
   // checks
   chk_alert_onset: assert property (@(posedge core_clk) disable iff (!rst_n)
      err_now |-> ##[1:ON_CYC] !alert_n)
      else $error("alert not low within onset delay");

   chk_status_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      err_now |=> cur.status && !alert_n)
      else $error("status not set with alert");

   chk_no_exec_alert: assert property (@(posedge core_clk)
      disable iff (!rst_n) !alert_n |-> !exec_valid)
      else $error("command executed during alert window");

   chk_pl4_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_now && cur.lat == 3'h1 ##1 (run_ok && cur.lat == 3'h1) [*4]
      |=> exec_valid)
      else $error("command not executed four clocks later");

   chk_pl_off_direct: assert property (@(posedge core_clk)
      disable iff (!rst_n) acc_now && !pl_en |=> exec_valid &&
      exec_word == $past(cmd_word))
      else $error("disabled mode did not pass command directly");

   chk_log_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      cur.status |=> $stable(cur.log))
      else $error("error log changed while status set");

   chk_alert_width: assert property (@(posedge core_clk)
      disable iff (!rst_n) $rose(alert_n) |-> $past(cur.cnt) >= WIN_CNT &&
      $past(banks_idle))
      else $error("alert released too early");

   chk_status_only_err: assert property (@(posedge core_clk)
      disable iff (!rst_n) $rose(cur.status) |-> $past(err_now))
      else $error("status set without an error");

   chk_sre_to_pd: assert property (@(posedge core_clk) disable iff (!rst_n)
      err_now && is_sre |=> pd_enter && !exec_valid)
      else $error("faulty self-refresh entry not turned to power-down");

   chk_persist_resume: assert property (@(posedge core_clk)
      disable iff (!rst_n) $rose(alert_n) && cur.persist && pl_en
      |-> chk_on)
      else $error("persistent mode did not resume checking");

endmodule : capc_checker

// ---- tb/capc_ctrl_model.sv ----
// controller-side model driving the command/address pins
`timescale 1ns/10ps
module capc_ctrl_model (
   input  wire logic        core_clk,
   output logic             cke,
   output logic             cs_n,
   output logic             act_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [13:0]      addr,
   output logic [1:0]       ba,
   output logic             bg,
   output logic             par
);
   ////////////////////////////////////////////////////////////////////////////
   // bus starts deselected with the clock enable high
   initial begin
      cke = 1'b1;
      cs_n = 1'b1;
      {bg, ba, act_n, ras_n, cas_n, we_n, addr} = 21'h0;
      par = 1'b0;
   end

   // one selected cycle, then a deselect; the inverted word on the
   // deselect keeps stale command bits from passing for a real command
   task automatic issue(input logic [20:0] w, input logic bad, k);
      @(posedge core_clk);
      cs_n <= 1'b0;
      cke <= k;
      {bg, ba, act_n, ras_n, cas_n, we_n, addr} <= w;
      par <= (^w) ^ bad;
      @(posedge core_clk);
      cs_n <= 1'b1;
      cke <= 1'b1;
      {bg, ba, act_n, ras_n, cas_n, we_n, addr} <= ~w;
      par <= ~((^w) ^ bad);
   endtask : issue
endmodule : capc_ctrl_model

// ---- tb/tb.sv ----
// self-checking bench for the command/address parity checker
`timescale 1ns/10ps
`include "capc_consts.svh"
module tb;
   logic        core_clk, nrst, hsel, hwrite, hreadyout, hresp;
   logic        cke, cs_n, act_n, ras_n, cas_n, we_n, bg, par;
   logic        core_idle, banks_idle, exec_valid, prech_all;
   logic        pd_enter, alert_n;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans, ba;
   logic [2:0]  hsize, pl_cycles;
   logic [13:0] addr;
   logic [20:0] exec_word;
   wire         hready;
   int          miscompares = 0, comparisons = 0, cyc = 0, execn = 0;
   int          prechn = 0, pdn = 0, lowc = 0, lastlow = 0, tfall = 0;
   int          tiss, e;
   localparam logic [20:0] SRE = 21'h166c3a;

   // the single slave drives the bus ready
   assign hready = hreadyout;

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   capc_checker dut_u (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cke(cke), .cs_n(cs_n),
      .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .addr(addr), .ba(ba), .bg(bg), .par(par), .core_idle(core_idle),
      .banks_idle(banks_idle), .exec_valid(exec_valid),
      .exec_word(exec_word), .prech_all(prech_all), .pd_enter(pd_enter),
      .pl_cycles(pl_cycles), .alert_n(alert_n));

   capc_ctrl_model ctrl_u (.core_clk(core_clk), .cke(cke), .cs_n(cs_n),
      .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .addr(addr), .ba(ba), .bg(bg), .par(par));

   ////////////////////////////////////////////////////////////////////////////
   // event counters; alert low time is measured from fall to release
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (exec_valid === 1'b1) execn <= execn + 1;
      if (prech_all === 1'b1) prechn <= prechn + 1;
      if (pd_enter === 1'b1) pdn <= pdn + 1;
      if (alert_n === 1'b0) begin
         lowc <= lowc + 1;
         if (lowc == 0) tfall <= cyc;
      end else if (lowc != 0) begin
         lastlow <= lowc;
         lowc <= 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] x, g);
      comparisons++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   // one single transfer: address phase, then data phase, both held
   task automatic bus(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 40);
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 80);
      q = hrdata;
      hsel <= 1'b0;
      if (n >= 80) begin
         miscompares++;
         finish_test();
      end
   endtask : bus

   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input string nm, input logic [31:0] a, x);
      bus(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask : rd

   // issue a command and measure pin-to-execute cycles; -1 means dropped
   task automatic cmd(input logic [20:0] w, input logic bad, k, input int d);
      int n;
      #1;
      tiss = cyc + 1;
      ctrl_u.issue(w, bad, k);
      n = 1;
      #1;
      while (exec_valid !== 1'b1 && n < 12) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("exec delay", (d < 0) ? 12 : d, n);
      if (d >= 0) chk("exec word", w, exec_word);
   endtask : cmd

   task automatic wait_alert(input logic v);
      int n;
      n = 0;
      while (alert_n !== v && n < 60) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      // one more edge so the pulse counter has stored the low time
      @(posedge core_clk);
      #1;
      if (n >= 60) begin
         miscompares++;
         finish_test();
      end
   endtask : wait_alert

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : idle

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      core_idle = 1'b1;
      banks_idle = 1'b1;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      idle(4);
      chk("pl cycles", 0, pl_cycles);
      chk("alert idle", 1, alert_n);
      chk("reset quiet", 0, execn);
      rd("mode", `CAPC_OFS_MODE, 0);
      rd("state", `CAPC_OFS_STAT, 0);
      wr(32'h40, 32'hffff_ffff);
      rd("unmapped", 32'h40, 0);
      chk("resp", 0, hresp);
      // checking off: bad parity still runs, no delay added
      cmd(21'h0a5a5, 1'b1, 1'b1, 3);
      chk("no alert", 1, alert_n);
      // latency codes 1 to 3, and reserved code 4 acting as disabled
      for (int i = 1; i < 5; i++) begin
         wr(`CAPC_OFS_MODE, 0);
         idle(8);
         wr(`CAPC_OFS_MODE, i);
         idle(8);
         e = (i < 4) ? i + 3 : 0;
         chk("pl cycles", e, pl_cycles);
         rd("mode", `CAPC_OFS_MODE, 0);
         rd("checking", `CAPC_OFS_STAT, (i < 4) ? 8 : 0);
         cmd(21'h1f0000 ^ (i << 3), 1'b0, 1'b1, 3 + e);
      end
      // faulty self-refresh entry with latency four, core and banks busy
      wr(`CAPC_OFS_MODE, 0);
      idle(8);
      wr(`CAPC_OFS_MODE, 1);
      idle(8);
      core_idle <= 1'b0;
      banks_idle <= 1'b0;
      e = execn;
      cmd(SRE, 1'b1, 1'b0, -1);
      chk("alert onset", 1, tfall > tiss && tfall - tiss <= 4);
      chk("power down", 1, pdn);
      chk("no precharge", 0, prechn);
      rd("status", `CAPC_OFS_MODE, 32'h10);
      core_idle <= 1'b1;
      idle(`CAPC_TRAS_CYC + 4);
      chk("precharge", 1, prechn);
      idle(`CAPC_WINDOW_CYC);
      chk("alert held", 0, alert_n);
      banks_idle <= 1'b1;
      wait_alert(1'b1);
      chk("pulse width", 1, lastlow >= `CAPC_WINDOW_CYC);
      chk("dropped", e, execn);
      wr(`CAPC_OFS_PAGE, 1);
      rd("log0", `CAPC_OFS_LOG0, SRE[7:0]);
      rd("log1", `CAPC_OFS_LOG1, SRE[15:8]);
      rd("log2", `CAPC_OFS_LOG2, {~^SRE, SRE[17], 1'b0, SRE[20:18],
         1'b0, SRE[16]});
      rd("log3", `CAPC_OFS_LOG3, 8'h48);
      // status still set: runs delayed but unchecked, log untouched
      cmd(21'h0f0f0, 1'b1, 1'b1, 7);
      chk("no alert", 1, alert_n);
      rd("log kept", `CAPC_OFS_LOG0, SRE[7:0]);
      cmd(21'h024000, 1'b0, 1'b1, 7);
      wr(`CAPC_OFS_MODE, 1);
      wr(`CAPC_OFS_MODE, 32'h11);
      rd("status clear", `CAPC_OFS_MODE, 0);
      // persistent mode: checking resumes while status stays set
      wr(`CAPC_OFS_MODE, 32'h201);
      cmd(21'h00123, 1'b1, 1'b1, -1);
      wait_alert(1'b1);
      chk("pulse width", 1, lastlow >= `CAPC_WINDOW_CYC);
      rd("status kept", `CAPC_OFS_MODE, 32'h210);
      cmd(21'h00456, 1'b1, 1'b1, -1);
      chk("alert again", 1, tfall > tiss);
      wait_alert(1'b1);
      finish_test();
   end
endmodule : tb
